// ===== src/vlsf_regs.svh
`ifndef VLSF_REGS_SVH
`define VLSF_REGS_SVH
// Symbol geometry
`define VLSF_SYM_W        35
`define VLSF_LEG_W        28
`define VLSF_DIN_W        24
// Field positions inside the 35-bit symbol (same on both link ends)
`define VLSF_POS_CLK1     34
`define VLSF_POS_CLK0     0
`define VLSF_POS_DIN      1
`define VLSF_POS_DE       25
`define VLSF_POS_HS       26
`define VLSF_POS_VS       27
`define VLSF_POS_CTL      28
`define VLSF_POS_AUD      29
`define VLSF_POS_BAL      33
// Legacy 28-bit symbol field positions
`define VLSF_LPOS_DIN     1
`define VLSF_LPOS_SYNC    25
`define VLSF_LPOS_BAL     26
// Scrambler seed and taps (x^16+x^14+x^13+x^11+1)
`define VLSF_SCR_SEED     16'hACE1
// Lock time in pixel clock periods
`define VLSF_LOCK_CYC     131
// Return channel frame: 1 I2C bit, 4 GPIO bits, 3 CRC bits
`define VLSF_RET_W        8
`define VLSF_RET_POS_I2C  0
`define VLSF_RET_POS_GPIO 1
`define VLSF_RET_POS_CRC  5
// Pixel clock limits in MHz
`define VLSF_PCLK_MIN_MHZ 5
`define VLSF_PCLK_MAX_MHZ 85
`define VLSF_LEG_MAX_MHZ  65
`endif

// ===== src/vlsf_pkg.sv
package vlsf_pkg;
  typedef enum logic [1:0] {BR_DISPLAY, BR_CAMERA} vlsf_bridge_mode_t;
  typedef enum {ST_DOWN, ST_LOCK, ST_RUN} vlsf_link_st_t;
endpackage

// ===== src/vlsf_scrambler.sv
`timescale 1ns/10ps
`include "vlsf_regs.svh"
// Additive LFSR scrambler, advances once per symbol
module vlsf_scrambler
  import vlsf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        advance,
  output logic      [15:0] mask
);
  logic [15:0] lfsr_q;
  logic        fb;

  assign fb   = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];
  assign mask = lfsr_q;

  // Reloaded with the seed until the link is locked so both ends restart aligned
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= `VLSF_SCR_SEED;
    end else if (!advance) begin
      lfsr_q <= `VLSF_SCR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], fb};
    end
  end
endmodule

// ===== src/vlsf_framer.sv
`timescale 1ns/10ps
`include "vlsf_regs.svh"
// Summary of operation
// - One 35-bit symbol per pixel clock
// - Symbol embeds clock marks with control, payload
// - Payload: 24 data, syncs, control, audio
// - Only the 24 data bits scrambled and DC balanced
// - Pixel clock 5 to 85 MHz
// - Line rate scales, 175 Mbps to 2.975 Gbps
// - Control embedded forward, slow return path
// - Return info arrives per symbol, shared pair
// - Return carries I2C, CRC, four GPIO
// - Display mode: local I2C forwarded remote
// - Camera mode: remote I2C replayed locally
// - Bridge yields on arbitration loss
// - Configuration via local I2C slave
// - Legacy mode: 28-bit symbols, 5-65 MHz
// - Legacy line rate 140 Mbps to 1.82 Gbps
// - Legacy chosen by strap or config bit
// - Serial bit interval is period over 35
// - Lock within 131 pixel clocks
module vlsf_framer
  import vlsf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        powerUp,
  input  wire logic [23:0] dinData,
  input  wire logic        dinDe,
  input  wire logic        dinHs,
  input  wire logic        dinVs,
  input  wire logic [3:0]  audioBits,
  input  wire logic        legacyStrap,
  input  wire logic        legacyCfg,
  input  wire logic        cameraMode,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_n,
  output logic             sclOut,
  output logic             sclOe_n,
  input  wire logic        retValid,
  input  wire logic [7:0]  retFrame,
  output logic [34:0]      symbolOut,
  output logic             symbolValid,
  output logic             legacyActive,
  output logic             linkLocked,
  output logic [3:0]       gpioOut,
  output logic             retCrcErr,
  output logic             arbLost,
  output logic             cfgWrite,
  output logic [7:0]       cfgData
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic [1:0] strapSync_q;
  logic [1:0] pwrSync_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic       scl;
  logic       sda;

  // Two stages; only stage two feeds logic
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclSync_q   <= 2'h3;
      sdaSync_q   <= 2'h3;
      strapSync_q <= 2'h0;
      pwrSync_q   <= 2'h0;
    end else begin
      sclSync_q   <= {sclSync_q[0], sclIn};
      sdaSync_q   <= {sdaSync_q[0], sdaIn};
      strapSync_q <= {strapSync_q[0], legacyStrap};
      pwrSync_q   <= {pwrSync_q[0], powerUp};
    end
  end
  assign scl = sclSync_q[1];
  assign sda = sdaSync_q[1];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclPrev_q <= 1'h1;
      sdaPrev_q <= 1'h1;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
    end
  end

  // ---------------------------------------------------------------
  // Mode selection and lock
  // ---------------------------------------------------------------
  logic          legacy_q;
  vlsf_link_st_t st_q;
  logic [7:0]    lockCnt_q;

  // Mode is caught only while the link is down: changing symbol size
  // mid-stream would desynchronise the far end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      legacy_q <= 1'h0;
    end else if (st_q == ST_DOWN) begin
      legacy_q <= strapSync_q[1] | legacyCfg;
    end
  end
  assign legacyActive = legacy_q;

  // Power-up lock sequence
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q      <= ST_DOWN;
      lockCnt_q <= 8'h00;
    end else if (!pwrSync_q[1]) begin
      st_q      <= ST_DOWN;
      lockCnt_q <= 8'h00;
    end else begin
      unique case (st_q)
        ST_DOWN: begin
          st_q      <= ST_LOCK;
          lockCnt_q <= 8'h00;
        end
        ST_LOCK: begin
          lockCnt_q <= lockCnt_q + 8'h01;
          if (lockCnt_q == 8'(`VLSF_LOCK_CYC - 2)) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end
  assign linkLocked = (st_q == ST_RUN);

  // ---------------------------------------------------------------
  // I2C bridge: start/stop and bit capture
  // ---------------------------------------------------------------
  logic       startDet;
  logic       stopDet;
  logic       sclRise;
  logic       busy_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic       ctlBit_q;
  logic       ctlPend_q;

  assign startDet = scl & sclPrev_q & sdaPrev_q & ~sda;
  assign stopDet  = scl & sclPrev_q & ~sdaPrev_q & sda;
  assign sclRise  = scl & ~sclPrev_q;

  // Display mode: each sampled local bit is queued for the forward
  // control slot; only one bit per symbol fits, fine at I2C rates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_q    <= 1'h0;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      ctlBit_q  <= 1'h0;
      ctlPend_q <= 1'h0;
    end else begin
      if (startDet) begin
        busy_q   <= 1'h1;
        bitCnt_q <= 4'h0;
      end else if (stopDet) begin
        busy_q <= 1'h0;
      end else if (busy_q && sclRise) begin
        shift_q  <= {shift_q[6:0], sda};
        bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
      end
      if (busy_q && sclRise && !cameraMode) begin
        ctlBit_q  <= sda;
        ctlPend_q <= 1'h1;
      end else if (linkLocked) begin
        ctlPend_q <= 1'h0;
      end
    end
  end

  // Each complete byte seen locally is offered as configuration data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfgWrite <= 1'h0;
      cfgData  <= 8'h00;
    end else begin
      cfgWrite <= busy_q & sclRise & (bitCnt_q == 4'h7);
      if (busy_q && sclRise && bitCnt_q == 4'h7) begin
        cfgData <= {shift_q[6:0], sda};
      end
    end
  end

  // ---------------------------------------------------------------
  // Return path decode
  // ---------------------------------------------------------------
  logic [2:0] crcCalc;
  logic       remI2c_q;

  function automatic logic [2:0] crc3(input logic [4:0] d);
    crc3 = {d[4] ^ d[2] ^ d[1], d[3] ^ d[1] ^ d[0], d[4] ^ d[3] ^ d[0]};
  endfunction

  assign crcCalc = crc3(retFrame[`VLSF_RET_POS_CRC-1:0]);

  // Frame delivered once per symbol; bad CRC discards it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gpioOut   <= 4'h0;
      remI2c_q  <= 1'h1;
      retCrcErr <= 1'h0;
    end else if (retValid) begin
      retCrcErr <= (crcCalc != retFrame[7:5]);
      if (crcCalc == retFrame[7:5]) begin
        gpioOut  <= retFrame[4:1];
        remI2c_q <= retFrame[`VLSF_RET_POS_I2C];
      end
    end else begin
      retCrcErr <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Camera mode master replay with arbitration
  // ---------------------------------------------------------------
  logic yield_q;

  // Drive SDA low only; if bus reads low while we release, we lost
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      yield_q <= 1'h0;
      arbLost <= 1'h0;
    end else begin
      arbLost <= 1'h0;
      if (stopDet || !cameraMode) begin
        yield_q <= 1'h0;
      end else if (sclRise && remI2c_q && !sda) begin
        yield_q <= 1'h1;
        arbLost <= 1'h1;
      end
    end
  end

  // Low-active enables: pulled low only, open-drain style
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sdaOe_n <= 1'h1;
    end else begin
      sdaOe_n <= ~(cameraMode & linkLocked & ~yield_q & ~remI2c_q);
    end
  end
  assign sdaOut  = 1'h0;
  assign sclOut  = 1'h0;
  assign sclOe_n = 1'h1; // Clock stretching not used

  // ---------------------------------------------------------------
  // Forward symbol assembly
  // ---------------------------------------------------------------
  logic [15:0] scrMask;
  logic [23:0] scrData;
  logic        balInv;
  logic [23:0] payload;

  vlsf_scrambler u_scr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .advance (linkLocked),
    .mask    (scrMask)
  );

  function automatic logic [4:0] ones24(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 24; i++) begin
      n = n + 5'(v[i]);
    end
    ones24 = n;
  endfunction

  // Scramble then invert if more than half are ones
  assign scrData = dinData ^ {scrMask[7:0], scrMask};
  assign balInv  = (ones24(scrData) > 5'd12);
  assign payload = balInv ? ~scrData : scrData;

  // Serialiser downstream shifts one bit per period/35
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      symbolOut   <= 35'h000000000;
      symbolValid <= 1'h0;
    end else begin
      symbolValid <= linkLocked;
      if (!linkLocked) begin
        symbolOut <= 35'h000000000;
      end else if (legacy_q) begin
        // Upper bits zero in 28-bit mode
        symbolOut <= {7'h00, 1'h1, balInv, ^{dinDe, dinHs, dinVs},
                      payload, 1'h0};
      end else begin
        symbolOut <= {1'h1, balInv, audioBits, ctlBit_q & ctlPend_q,
                      dinVs, dinHs, dinDe, payload, 1'h0};
      end
    end
  end
endmodule

// ===== test/vlsf_far_end.sv
`timescale 1ns/10ps
// ------------------------------
// Far-end return channel model
// ------------------------------
module vlsf_far_end (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       send,
  input  wire logic       badCrc,
  input  wire logic [3:0] gpioSend,
  output logic            retValid,
  output logic [7:0]      retFrame
);
  logic [4:0] d;
  logic [2:0] crc;
  // I2C bit idles at 0; frame layout shared with the framer return decode
  assign d = {gpioSend, 1'b0};
  assign crc = {d[4]^d[2]^d[1], d[3]^d[1]^d[0], d[4]^d[3]^d[0]};
  // One frame per command; a stale bus inverts each cycle, so it alternates between the inverse and old data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retValid <= 1'b0;
      retFrame <= 8'h00;
    end else if (send) begin
      retValid <= 1'b1;
      retFrame <= {crc ^ {2'b00, badCrc}, d};
    end else begin
      retValid <= 1'b0;
      retFrame <= ~retFrame;
    end
  end
endmodule

// ===== test/vlsf_framer_chk.sv
`timescale 1ns/10ps
// ------------------------------
// Port checker
// ------------------------------
module vlsf_framer_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        powerUp,
  input wire logic        dinDe,
  input wire logic        dinHs,
  input wire logic        dinVs,
  input wire logic [3:0]  audioBits,
  input wire logic        retValid,
  input wire logic [7:0]  retFrame,
  input wire logic [34:0] symbolOut,
  input wire logic        symbolValid,
  input wire logic        legacyActive,
  input wire logic        linkLocked,
  input wire logic [3:0]  gpioOut,
  input wire logic        retCrcErr
);
  logic crcOk;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Return frame check bits, recomputed independently
  assign crcOk = retFrame[7:5] == {retFrame[4]^retFrame[2]^retFrame[1],
    retFrame[3]^retFrame[1]^retFrame[0], retFrame[4]^retFrame[3]^retFrame[0]};
  AST_NO_SYM_UNLOCKED: assert property (!linkLocked |=> !symbolValid)
    else $error("symbol sent while unlocked");
  AST_SYM_EACH_CYCLE: assert property (linkLocked |=> symbolValid)
    else $error("symbol slot missed");
  AST_CLOCK_MARKS: assert property (symbolValid && !legacyActive
    |-> symbolOut[34] && !symbolOut[0])
    else $error("clock marks wrong");
  AST_FIELDS: assert property (symbolValid && !legacyActive |->
    symbolOut[32:29] == $past(audioBits) && symbolOut[27:25] ==
    {$past(dinVs), $past(dinHs), $past(dinDe)})
    else $error("control or audio field wrong");
  AST_BALANCE: assert property (symbolValid && !legacyActive
    |-> $countones(symbolOut[24:1]) <= 12)
    else $error("payload not balanced");
  AST_LEGACY_FORM: assert property (symbolValid && legacyActive
    |-> symbolOut[34:27] == 8'h01 && !symbolOut[0])
    else $error("legacy symbol form wrong");
  AST_LOCK_TIME: assert property ($rose(powerUp)
    |-> ##[1:140] linkLocked)
    else $error("lock too slow");
  AST_GPIO_UPDATE: assert property (retValid && crcOk
    |=> gpioOut == $past(retFrame[4:1]))
    else $error("gpio not updated");
  AST_CRC_ERR: assert property (retValid && !crcOk |=> retCrcErr)
    else $error("bad return frame not flagged");
endmodule
bind vlsf_framer vlsf_framer_chk vlsf_framer_chk_i (.*);

// ===== test/vlsf_framer_tb.sv
`timescale 1ns/10ps
// ------------------------------
// Framer testbench
// ------------------------------
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, s); fail_count++; end end
module vlsf_framer_tb;
  import vlsf_pkg::*;
  typedef struct {
    logic [23:0] din; logic [2:0] syn; logic [3:0] aud;
    logic [3:0]  gp;  logic bad;       logic [3:0] expGp;
  } vlsf_row_t;
  vlsf_row_t rows [4] = '{
    '{24'hFFFFFF, 3'h7, 4'hF, 4'hA, 1'b0, 4'hA},
    '{24'h000000, 3'h0, 4'h0, 4'h5, 1'b1, 4'hA},
    '{24'hA5A5A5, 3'h2, 4'h9, 4'h0, 1'b0, 4'h0},
    '{24'h123456, 3'h5, 4'h6, 4'hF, 1'b0, 4'hF}};
  logic clk_sys = 0, rstn = 0, powerUp = 0, legacyStrap = 0, legacyCfg = 0;
  logic cameraMode = 0, sclTb = 1, sdaTb = 1, send = 0, badCrc = 0;
  logic [23:0] dinData = 24'h000000;
  logic [2:0] syn = 3'h0;
  logic [3:0] audioBits = 4'h0, gpioSend = 4'h0;
  logic sdaOut, sdaOe_n, sclOut, sclOe_n, retValid, symbolValid;
  logic legacyActive, linkLocked, retCrcErr, arbLost, cfgWrite;
  logic errSeen = 0, wrSeen = 0;
  logic [7:0] retFrame, cfgData;
  logic [34:0] symbolOut;
  logic [3:0] gpioOut;
  int fail_count = 0, samples_checked = 0, n;
  always #5 clk_sys = ~clk_sys;
  // Pulses stand one cycle, so they are caught at the edge itself
  always @(posedge clk_sys) begin
    if (retCrcErr === 1'b1) errSeen <= 1'b1;
    if (cfgWrite === 1'b1) wrSeen <= 1'b1;
  end
  vlsf_far_end vlsf_far_end_i (.clk_sys(clk_sys), .rstn(rstn), .send(send),
    .badCrc(badCrc), .gpioSend(gpioSend), .retValid(retValid),
    .retFrame(retFrame));
  // Open-drain lines: wired-and of bench and design drivers
  vlsf_framer vlsf_framer_i (.clk_sys(clk_sys), .rstn(rstn),
    .powerUp(powerUp), .dinData(dinData), .dinDe(syn[0]), .dinHs(syn[1]),
    .dinVs(syn[2]), .audioBits(audioBits), .legacyStrap(legacyStrap),
    .legacyCfg(legacyCfg), .cameraMode(cameraMode),
    .sclIn(sclTb & (sclOe_n | sclOut)), .sdaIn(sdaTb & (sdaOe_n | sdaOut)),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .retValid(retValid), .retFrame(retFrame), .symbolOut(symbolOut),
    .symbolValid(symbolValid), .legacyActive(legacyActive),
    .linkLocked(linkLocked), .gpioOut(gpioOut), .retCrcErr(retCrcErr),
    .arbLost(arbLost), .cfgWrite(cfgWrite), .cfgData(cfgData));
  task automatic summarize();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Power up and count cycles until the link reports lock
  task automatic lockUp();
    powerUp = 1;
    n = 0;
    while (linkLocked !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("lock window", 1'b1, n >= 131 && n <= 137)
  endtask
  task automatic i2cSet(input logic c, input logic d);
    sclTb = c;
    sdaTb = d;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    #50us;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rstn = 1;
    `CHK("reset sdaOe_n", 1'b1, sdaOe_n)
    `CHK("reset symbolValid", 1'b0, symbolValid)
    lockUp();
    $display("test lock done");
    foreach (rows[i]) begin
      {dinData, syn, audioBits} = {rows[i].din, rows[i].syn, rows[i].aud};
      {gpioSend, badCrc, send, errSeen} = {rows[i].gp, rows[i].bad, 2'b10};
      @(negedge clk_sys);
      send = 0;
      `CHK("marks", 2'b10, {symbolOut[34], symbolOut[0]})
      `CHK("sync", rows[i].syn, symbolOut[27:25])
      `CHK("audio", rows[i].aud, symbolOut[32:29])
      repeat (3) @(negedge clk_sys);
      `CHK("gpio", rows[i].expGp, gpioOut)
      `CHK("crc flag", rows[i].bad, errSeen)
    end
    $display("test rows done");
    // Display mode: START, byte 0xA5 MSB first, STOP
    i2cSet(1, 0);
    for (int b = 7; b >= 0; b--) begin
      i2cSet(0, b[0] ? 8'hA5 >> b & 1 : 8'hA5 >> b & 1);
      i2cSet(1, (8'hA5 >> b) & 1);
    end
    i2cSet(0, 0);
    i2cSet(1, 0);
    i2cSet(1, 1);
    `CHK("cfg write", 1'b1, wrSeen)
    `CHK("cfg byte", 8'hA5, cfgData)
    $display("test i2c done");
    cameraMode = 1;
    repeat (4) @(negedge clk_sys);
    `CHK("camera drive", 1'b0, sdaOe_n)
    `CHK("camera level", 1'b0, sdaOut)
    `CHK("no stretch", 1'b1, sclOe_n)
    `CHK("scl level", 1'b0, sclOut)
    `CHK("no arb loss", 1'b0, arbLost)
    cameraMode = 0;
    $display("test camera done");
    // Legacy chosen by either source, only taken while the link is down
    for (int s = 0; s < 2; s++) begin
      powerUp = 0;
      repeat (8) @(negedge clk_sys);
      {legacyStrap, legacyCfg} = s ? 2'b01 : 2'b10;
      lockUp();
      repeat (2) @(negedge clk_sys);
      `CHK("legacy", 1'b1, legacyActive)
      `CHK("legacy head", 8'h01, symbolOut[34:27])
      `CHK("legacy sync", ^syn, symbolOut[25])
    end
    $display("test legacy done");
    // Reset in mid-run drops lock and the symbol stream at once
    rstn = 0;
    @(negedge clk_sys);
    `CHK("mid reset lock", 1'b0, linkLocked)
    `CHK("mid reset valid", 1'b0, symbolValid)
    rstn = 1;
    repeat (2) @(negedge clk_sys);
    `CHK("mid reset hold", 1'b0, symbolValid)
    $display("test mid reset done");
    summarize();
  end
endmodule
